// ==== cie_core.sv ====
// Function
// - Literal load writes W, flags untouched
// - Option load copies W, flags untouched
// - Return: W gets literal, PC gets stack
// - Return takes two cycles, prefetch discarded
// - Sleep clears watchdog counter and prescaler
// - Sleep sets timeout, clears powerdown, keeps wake
// - Sleep stops oscillator, no more instructions
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - File address 0..31, d picks destination
// - Subtract W from file, route, set flags
`timescale 1ns/10ps
module cie_core
  import cie_pkg::*;
#(
  parameter int unsigned FILE_DEPTH = 32, // File registers
  parameter int unsigned PC_W       = 9   // Program counter width
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire cie_axil_req_s req,
  output cie_axil_rsp_s      rsp,
  input  wire logic          wake_req,
  output logic               watchdog_counter_clr,
  output logic               prescaler_clr,
  output logic               sleeping,
  output logic [7:0]         option_cfg
);

  // ------------------------------------------------------------
  // Bus slave state
  // ------------------------------------------------------------
  logic              aw_free_q; // Address slot empty
  logic              w_free_q;  // Data slot empty
  logic [AXI_AW-1:0] awaddr_q;  // Held write address
  logic [AXI_DW-1:0] wdata_q;   // Held write data
  logic [3:0]        wstrb_q;   // Held byte enables
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              ar_free_q; // Read address slot empty
  logic              rvalid_q;
  logic [AXI_DW-1:0] rdata_q;
  logic [1:0]        rresp_q;

  // Core state
  logic [7:0]        w_q;       // Working accumulator
  logic [7:0]        status_q;
  logic [7:0]        option_q;
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   stack_q;   // stack_top_entry
  logic [7:0]        file_q [FILE_DEPTH];
  cie_state_e        st_q;
  logic              wdog_clr_q;
  logic              pre_clr_q;

  // Outputs straight from flops
  assign rsp = '{awready: aw_free_q, wready: w_free_q,
                 bvalid: bvalid_q, bresp: bresp_q,
                 arready: ar_free_q, rvalid: rvalid_q,
                 rdata: rdata_q, rresp: rresp_q};
  assign watchdog_counter_clr = wdog_clr_q;
  assign prescaler_clr        = pre_clr_q;
  assign sleeping             = st_q[2];
  assign option_cfg           = option_q;

  // ------------------------------------------------------------
  // Write decode and instruction fields
  // ------------------------------------------------------------
  logic       commit;   // Both halves of a write present
  logic       sw_wr;    // Low byte lane enabled
  logic       exec;     // Instruction runs this cycle
  logic       wr_ok;    // Write lands somewhere
  logic       file_op;  // File register instruction
  logic       dest_f;   // Result goes to file register
  logic [4:0] fidx;     // File address
  logic [7:0] lit;      // Immediate operand
  logic [7:0] fsel;     // Selected file register
  logic       carry;
  cie_op_e    op;

  assign commit = !aw_free_q && !w_free_q && !bvalid_q;
  assign sw_wr  = commit && wstrb_q[0];
  assign op     = cie_op_e'(wdata_q[OP_LSB +: OP_W]);
  assign lit    = wdata_q[7:0];
  assign fidx   = wdata_q[4:0];
  assign dest_f = wdata_q[D_BIT];
  assign fsel   = file_q[fidx];
  assign carry  = status_q[ST_C];

  // Refused while flushing or asleep, so nothing runs then
  assign exec = commit && (awaddr_q == OFS_INSTR) && (&wstrb_q[1:0])
                && (st_q == CS_RUN)
                && (wdata_q[OP_LSB +: OP_W] <= OP_SUB);
  assign file_op = exec && (op == OP_ROL || op == OP_ROR ||
                            op == OP_SUB);

  // Register strobes from software
  logic sw_w, sw_st, sw_pc, sw_stk, sw_file;
  assign sw_w    = sw_wr && (awaddr_q == OFS_WREG);
  assign sw_st   = sw_wr && (awaddr_q == OFS_STATUS);
  assign sw_pc   = sw_wr && (awaddr_q == OFS_PC);
  assign sw_stk  = sw_wr && (awaddr_q == OFS_STACK);
  assign sw_file = sw_wr && awaddr_q[7];
  assign wr_ok   = exec || sw_w || sw_st || sw_pc || sw_stk || sw_file;

  // ------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------
  logic [8:0] sub_full; // Carry out is the no-borrow bit
  logic [4:0] sub_lo;   // Low nibble, for digit carry
  logic [7:0] alu_res;

  // Two's complement: f + ~W + 1
  assign sub_full = {1'b0, fsel} + {1'b0, ~w_q} + 9'h001;
  assign sub_lo   = {1'b0, fsel[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;

  // Result of the file register instructions
  always_comb begin
    unique case (op)
      OP_ROL:  alu_res = {fsel[6:0], carry};
      OP_ROR:  alu_res = {carry, fsel[7:1]};
      OP_SUB:  alu_res = sub_full[7:0];
      default: alu_res = fsel;
    endcase
  end

  // ------------------------------------------------------------
  // Write channels
  // ------------------------------------------------------------
  // Address and data slots fill in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_free_q <= 1'b1;
      w_free_q  <= 1'b1;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (aw_free_q && req.awvalid) begin
        aw_free_q <= 1'b0;
        awaddr_q  <= req.awaddr;
      end else if (commit) begin
        aw_free_q <= 1'b1;
      end
      if (w_free_q && req.wvalid) begin
        w_free_q <= 1'b0;
        wdata_q  <= req.wdata;
        wstrb_q  <= req.wstrb;
      end else if (commit) begin
        w_free_q <= 1'b1;
      end
    end
  end

  // Write response; refused writes answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic [AXI_DW-1:0] rd_data;
  logic              rd_ok;

  // Read mux; unmapped reads return zero with an error
  always_comb begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (req.araddr[7]) begin
      rd_data[7:0] = file_q[req.araddr[6:2]];
    end else begin
      unique case (req.araddr)
        OFS_INSTR:  rd_data = '0;
        OFS_WREG:   rd_data[7:0] = w_q;
        OFS_STATUS: rd_data[7:0] = status_q;
        OFS_OPTION: rd_data[7:0] = option_q;
        OFS_PC:     rd_data[PC_W-1:0] = pc_q;
        OFS_STACK:  rd_data[PC_W-1:0] = stack_q;
        OFS_CORE:   rd_data[2:0] = st_q;
        default:    rd_ok = 1'b0;
      endcase
    end
  end

  // Data is sampled when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_free_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (ar_free_q && req.arvalid) begin
      ar_free_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && req.rready) begin
      ar_free_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Architectural registers
  // ------------------------------------------------------------
  // Working accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= W_RST;
    end else if (sw_w) begin
      w_q <= wdata_q[7:0];
    end else if (exec && (op == OP_LDL || op == OP_RET)) begin
      w_q <= lit;
    end else if (file_op && !dest_f) begin
      w_q <= alu_res;
    end
  end

  // File registers; written back only when d is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_q[i] <= FILE_RST;
      end
    end else if (sw_file) begin
      file_q[awaddr_q[6:2]] <= wdata_q[7:0];
    end else if (file_op && dest_f) begin
      file_q[fidx] <= alu_res;
    end
  end

  // Status flags; load, option and return leave them alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= STATUS_RST;
    end else if (sw_st) begin
      status_q <= (status_q & ~STATUS_MASK) | (wdata_q[7:0] & STATUS_MASK);
    end else if (exec) begin
      unique case (op)
        OP_ROL: status_q[ST_C] <= fsel[7];
        OP_ROR: status_q[ST_C] <= fsel[0];
        OP_SUB: begin
          status_q[ST_C]   <= sub_full[8];
          status_q[ST_DCY] <= sub_lo[4];
          status_q[ST_Z]  <= (sub_full[7:0] == 8'h00);
        end
        OP_SLP: begin
          status_q[ST_TMO] <= 1'b1;
          status_q[ST_PWR] <= 1'b0;
        end
        default: ; // No flag changes
      endcase
    end
  end

  // Option register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_q <= OPTION_RST;
    end else if (exec && op == OP_OPT) begin
      option_q <= w_q;
    end
  end

  // Program counter; every instruction but return steps by one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= '0;
    end else if (sw_pc) begin
      pc_q <= wdata_q[PC_W-1:0];
    end else if (exec && op == OP_RET) begin
      pc_q <= stack_q;
    end else if (exec) begin
      pc_q <= pc_q + PC_W'(1);
    end
  end

  // Top of stack, loaded by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_q <= '0;
    end else if (sw_stk) begin
      stack_q <= wdata_q[PC_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Core sequencing
  // ------------------------------------------------------------
  // Flush costs a cycle after return; sleep holds until wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CS_RUN;
    end else begin
      unique case (st_q)
        CS_RUN: begin
          if (exec && op == OP_RET) st_q <= CS_FLUSH;
          else if (exec && op == OP_SLP) st_q <= CS_SLEEP;
        end
        CS_FLUSH: st_q <= CS_RUN;
        CS_SLEEP: if (wake_req) st_q <= CS_RUN;
        default:  st_q <= CS_RUN; // Recover from a broken code
      endcase
    end
  end

  // One-cycle watchdog clear pulses on sleep entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_clr_q <= 1'b0;
      pre_clr_q <= 1'b0;
    end else begin
      wdog_clr_q <= exec && op == OP_SLP;
      pre_clr_q <= exec && op == OP_SLP;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic [8:0]      chk_rl, chk_rr; // {new carry, result}
  logic [2:0]      chk_sub;        // {dc, z, c} by comparison
  logic [7:0]      sub_ref;
  logic            wake_flag;
  logic [PC_W-1:0] pc_inc;
  assign chk_rl    = {fsel, carry};
  assign chk_rr    = {fsel[0], carry, fsel[7:1]};
  assign chk_sub   = {fsel[3:0] >= w_q[3:0], fsel == w_q, fsel >= w_q};
  assign sub_ref   = fsel - w_q;
  assign wake_flag = status_q[ST_WAKE];
  assign pc_inc    = pc_q + PC_W'(1);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_flush;
    (st_q == CS_FLUSH && !exec) ##1 (st_q == CS_RUN);
  endsequence
  sequence s_clr_pulse;
    (wdog_clr_q && pre_clr_q) ##1 (!wdog_clr_q && !pre_clr_q);
  endsequence

  a_load_lit: assert property (exec && op == OP_LDL |=>
    w_q == $past(lit) && $stable(status_q)) else $error("literal load");
  a_option_copy: assert property (exec && op == OP_OPT |=>
    option_q == $past(w_q) && $stable(status_q)) else $error("option");
  a_return_lit: assert property (exec && op == OP_RET |=>
    pc_q == $past(stack_q) && w_q == $past(lit) && $stable(status_q))
    else $error("return values");
  a_return_two: assert property (exec && op == OP_RET |=>
    s_flush) else $error("return flush");
  a_sleep_wdt: assert property (exec && op == OP_SLP |=>
    s_clr_pulse) else $error("watchdog clear");
  a_sleep_flags: assert property (exec && op == OP_SLP |=>
    status_q[ST_TMO] && !status_q[ST_PWR] && wake_flag == $past(wake_flag))
    else $error("sleep flags");
  // A wake that arrives right at entry may end sleep after one cycle
  a_sleep_halt: assert property (exec && op == OP_SLP |=>
    (st_q == CS_SLEEP && !exec) ##1
    ((st_q == CS_SLEEP && !exec) || $past(wake_req)))
    else $error("sleep halt");
  a_rot_left: assert property (exec && op == OP_ROL && !dest_f |=>
    {carry, w_q} == $past(chk_rl)) else $error("rotate left");
  a_rot_right: assert property (exec && op == OP_ROR && !dest_f |=>
    {carry, w_q} == $past(chk_rr)) else $error("rotate right");
  a_dest_file: assert property (file_op && dest_f |=>
    $stable(w_q)) else $error("destination");
  a_sub_result: assert property (exec && op == OP_SUB && !dest_f |=>
    w_q == $past(sub_ref)) else $error("subtract result");
  a_sub_flags: assert property (exec && op == OP_SUB |=>
    {status_q[ST_DCY], status_q[ST_Z], carry} == $past(chk_sub))
    else $error("subtract flags");
  a_idle_step: assert property (exec && op == OP_IDLE |=>
    pc_q == $past(pc_inc) && $stable(w_q) && $stable(status_q)
    && $stable(option_q)) else $error("idle");

endmodule // cie_core

// ==== cie_pkg.sv ====
// ------------------------------------------------------------
// Shared constants and types of the instruction executor
// ------------------------------------------------------------
package cie_pkg;

  // Bus geometry
  localparam int unsigned AXI_AW = 8;  // Byte address width
  localparam int unsigned AXI_DW = 32; // Data width

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00; // Issue an instruction
  localparam logic [7:0] OFS_WREG   = 8'h04; // Working accumulator
  localparam logic [7:0] OFS_STATUS = 8'h08; // Status flags
  localparam logic [7:0] OFS_OPTION = 8'h0c; // Option config, read only
  localparam logic [7:0] OFS_PC     = 8'h10; // Program counter
  localparam logic [7:0] OFS_STACK  = 8'h14; // stack_top_entry
  localparam logic [7:0] OFS_CORE   = 8'h18; // Core state, read only
  localparam logic [7:0] OFS_FILE   = 8'h80; // File registers 0..31

  // Instruction word fields
  localparam int unsigned OP_LSB = 12; // Opcode position
  localparam int unsigned OP_W   = 4;  // Opcode width
  localparam int unsigned D_BIT  = 8;  // Destination select bit

  // Status bit positions
  localparam int unsigned ST_C    = 0; // Carry
  localparam int unsigned ST_DCY  = 1; // digit_carry_flag
  localparam int unsigned ST_Z    = 2; // Zero
  localparam int unsigned ST_PWR  = 3; // powerdown_flag
  localparam int unsigned ST_TMO  = 4; // timeout_flag
  localparam int unsigned ST_WAKE = 7; // pin_change_wake_flag

  // Values after reset and write masks
  localparam logic [7:0] W_RST       = 8'h00;
  localparam logic [7:0] OPTION_RST  = 8'hff;
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [7:0] STATUS_MASK = 8'h87; // Software writable
  localparam logic [7:0] FILE_RST    = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Opcodes of the issued instruction word
  typedef enum logic [OP_W-1:0] {
    OP_IDLE = 4'h0, // idle_instr
    OP_LDL  = 4'h1, // load_literal_instr
    OP_OPT  = 4'h2, // Load option register
    OP_RET  = 4'h3, // return_literal_instr
    OP_SLP  = 4'h4, // Sleep
    OP_ROL  = 4'h5, // rotate_left_instr
    OP_ROR  = 4'h6, // rotate_right_instr
    OP_SUB  = 4'h7  // subtract_instr
  } cie_op_e;

  // Core states, one-hot
  typedef enum logic [2:0] {
    CS_RUN   = 3'b001, // Ready for the next instruction
    CS_FLUSH = 3'b010, // Discarding the prefetched word
    CS_SLEEP = 3'b100  // Oscillator stopped
  } cie_state_e;

  // Master to slave
  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [AXI_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } cie_axil_req_s;

  // Slave to master
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
  } cie_axil_rsp_s;

endpackage

// ==== core_instr_exec_subset_tb.sv ====
`timescale 1ns/10ps
module core_instr_exec_subset_tb
  import cie_pkg::*;
;
  // ----------------------------------------
  // Stimulus signals and model state
  // ----------------------------------------
  logic          aclk       = 1'b0; // Bus clock
  logic          aresetn    = 1'b0; // Sync reset
  cie_axil_req_s req        = '0;   // Master side
  cie_axil_rsp_s rsp;               // Slave side
  logic          wake_req   = 1'b0; // Leaves sleep
  logic          wd_clr;            // Watchdog clear
  logic          ps_clr;            // Prescaler clear
  logic          sleeping;          // Sleep state
  logic [7:0]    option_cfg;        // Option output
  int            n_mismatch = 0;    // Failures
  int            compares   = 0;    // Checks made
  int            n_clr      = 0;    // Clear pulse cycles
  int            w, st, opt, pc, stk; // Model registers
  int            fr [32];           // Model file
  int            ops [7]   = '{0, 1, 2, 3, 5, 6, 7}; // All but sleep
  int            sub_f [4] = '{16, 5, 0, 255};       // Minuends
  int            sub_w [4] = '{1, 5, 255, 0};        // Subtrahends

  // 25 MHz clock
  always #20 aclk = ~aclk;

  cie_core dut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .req                  (req),
    .rsp                  (rsp),
    .wake_req             (wake_req),
    .watchdog_counter_clr (wd_clr),
    .prescaler_clr        (ps_clr),
    .sleeping             (sleeping),
    .option_cfg           (option_cfg)
  );

  // Both clears must pulse in the same cycle; count the high cycles
  always @(posedge aclk) begin
    if (aresetn) begin
      if (wd_clr === 1'b1) n_clr <= n_clr + 1;
      cmp({31'h0, wd_clr}, {31'h0, ps_clr}, "clear pair");
    end
  end

  // ----------------------------------------
  // Comparison, bus tasks and model
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string s);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  // Address and data offered together; bready held until bvalid seen
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (n == 50) cmp(0, 1, "write hang");
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (n == 50) cmp(0, 1, "read hang");
  endtask

  task automatic wr(input logic [7:0] a, input int d,
                    input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = 4'hf);
    logic [1:0] r;
    axi_write(a, 32'(d), s, r);
    cmp({30'h0, r}, {30'h0, er}, "write resp");
  endtask

  task automatic rd_chk(input logic [7:0] a, input int e, input string s,
                        input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    cmp(d, 32'(e), s);
    cmp({30'h0, r}, {30'h0, er}, "read resp");
  endtask

  task automatic reset_model();
    w   = 0;
    st  = 8'h18;
    opt = 8'hff;
    pc  = 0;
    stk = 0;
    foreach (fr[i]) fr[i] = 0;
  endtask

  // Reads W, status, PC, stack, option and one file register back against the model
  task automatic chk_all(input int f);
    rd_chk(OFS_WREG, w, "w");
    rd_chk(OFS_STATUS, st, "status");
    rd_chk(OFS_PC, pc, "pc");
    rd_chk(OFS_STACK, stk, "stack");
    rd_chk(OFS_OPTION, opt, "option");
    rd_chk(8'(OFS_FILE + 4 * f), fr[f], "file");
    cmp({24'h0, option_cfg}, 32'(opt), "option pin");
  endtask

  // Integer model of one instruction; res < 0 means no file result
  task automatic model(input int op, input int d, input int k);
    int f, v, res, c;
    f   = k % 32;
    v   = fr[f];
    c   = st & 1;
    res = -1;
    pc  = (pc + 1) % 512;
    case (op)
      1: w = k;
      2: opt = w;
      3: begin w = k; pc = stk; end
      4: st = (st | 8'h10) & ~8'h08;
      5: begin res = ((v << 1) | c) & 255; c = v >> 7; end
      6: begin res = (v >> 1) | (c << 7); c = v & 1; end
      7: begin
        res = (v - w) & 255;
        c   = v >= w;
        st  = (st & ~6) | (((v & 15) >= (w & 15)) * 2) | ((res == 0) * 4);
      end
      default: ;
    endcase
    if (res >= 0) begin
      st = (st & ~1) | c;
      if (d == 1) fr[f] = res;
      else w = res;
    end
  endtask

  task automatic exec(input int op, input int d, input int k);
    wr(OFS_INSTR, op * 4096 + d * 256 + k);
    model(op, d, k);
    chk_all(k % 32);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    int         i, op, d, k, v;
    logic [1:0] r;
    void'($urandom(53375));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    chk_all(31);
    rd_chk(OFS_CORE, 1, "core run");
    $display("test reset done");
    // Random file contents and return address
    for (i = 0; i < 32; i++) begin
      fr[i] = $urandom % 256;
      wr(8'(OFS_FILE + 4 * i), fr[i]);
    end
    stk = $urandom % 512;
    wr(OFS_STACK, stk);
    pc = $urandom % 512;
    wr(OFS_PC, pc);
    // Random mix; file instructions among the first two hit file addresses 0 and 31
    for (i = 0; i < 60; i++) begin
      op = ops[$urandom % 7];
      d  = (op > 4) ? $urandom % 2 : 0;
      k  = (op < 5) ? $urandom % 256 : (i < 2) ? i * 31 : $urandom % 32;
      exec(op, d, k);
    end
    $display("test random done");
    // Borrow edges: nibble borrow, equal, full borrow, 255 minus zero
    for (i = 0; i < 4; i++) begin
      w      = sub_w[i];
      fr[31] = sub_f[i];
      wr(OFS_WREG, w);
      wr(OFS_FILE + 8'h7c, fr[31]);
      exec(7, i % 2, 31);
    end
    $display("test subtract done");
    // Probe the core state in the cycle after the return lands
    fork
      axi_write(OFS_INSTR, 32'h305a, 4'hf, r);
      begin
        repeat (2) @(posedge aclk);
        rd_chk(OFS_CORE, 2, "flush");
      end
    join
    cmp({30'h0, r}, {30'h0, RESP_OKAY}, "ret resp");
    model(3, 0, 8'h5a);
    chk_all(0);
    rd_chk(OFS_CORE, 1, "back to run");
    $display("test return done");
    // Sleep with every writable status bit set beforehand
    wr(OFS_STATUS, 8'hff);
    st = 8'h87 | (st & 8'h18);
    v  = n_clr;
    exec(4, 0, 0);
    cmp(32'(n_clr - v), 1, "clear pulse");
    cmp({31'h0, sleeping}, 1, "asleep");
    rd_chk(OFS_CORE, 4, "sleep state");
    wr(OFS_INSTR, 32'h1033, RESP_SLVERR);
    chk_all(0);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    @(posedge aclk);
    cmp({31'h0, sleeping}, 0, "awake");
    exec(0, 0, 0);
    $display("test sleep done");
    // Refused accesses leave everything as it was
    wr(8'h1c, 1, RESP_SLVERR);
    wr(OFS_OPTION, 0, RESP_SLVERR);
    wr(OFS_INSTR, 32'h8000, RESP_SLVERR);
    wr(OFS_INSTR, 32'h10a5, RESP_SLVERR, 4'h1);
    wr(OFS_WREG, 8'h77, RESP_SLVERR, 4'he);
    rd_chk(8'h1c, 0, "unmapped", RESP_SLVERR);
    chk_all(5);
    $display("test refuse done");
    // Reset again in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    chk_all(7);
    $display("test second reset done");
    end_of_test();
  end

  // Run takes about two thousand cycles; cut off well beyond that
  initial begin
    #(40 * 20000);
    cmp(0, 1, "timeout");
    end_of_test();
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

endmodule // core_instr_exec_subset_tb
